// file: src/sbs_pkg.sv
package sbs_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int SBS_ADDR_W = 18;
  localparam int SBS_LANES = 4;
  localparam int SBS_LANE_W = 9;
  localparam int SBS_DATA_W = 36;
  localparam int SBS_OFS_W = 2;
  localparam logic [1:0] SBS_OFS_ONE = 2'h1;
  localparam logic [1:0] SBS_OFS_ZERO = 2'h0;
  // ----------------------------------------
  // Access states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SBS_IDLE = 3'h1,
    SBS_READ = 3'h2,
    SBS_WRITE = 3'h4
  } sbs_state_t;
endpackage

// file: src/sbs_mem_if.sv
`timescale 1ns/1ps
interface sbs_mem_if #(
  parameter int AW = 18,
  parameter int DW = 36,
  parameter int LN = 4
);
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [LN-1:0] wlane;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output waddr, output wdata, output wlane, output raddr,
    input rdata);
  modport mem (input waddr, input wdata, input wlane, input raddr,
    output rdata);
endinterface

// file: src/sbs_mem.sv
`timescale 1ns/1ps
module sbs_mem
  import sbs_pkg::*;
#(
  parameter int AW = SBS_ADDR_W,
  parameter int LN = SBS_LANES,
  parameter int LW = SBS_LANE_W
) (
  input wire logic clk,
  sbs_mem_if.mem m
);
  logic [LN*LW-1:0] store [0:(1<<AW)-1];
  logic [LN*LW-1:0] rdata_reg;

  // ----------------------------------------
  // One write port with lane enables
  // ----------------------------------------
  // One process owns the array so no word has two drivers
  always_ff @(posedge clk) begin
    for (int i = 0; i < LN; i++) begin
      if (m.wlane[i]) begin
        store[m.waddr][i*LW +: LW] <= m.wdata[i*LW +: LW];
      end
    end
  end

  // Registered read keeps the output a clean flop
  always_ff @(posedge clk) begin
    rdata_reg <= store[m.raddr];
  end
  assign m.rdata = rdata_reg;
endmodule

// file: src/sbs_sram.sv
`timescale 1ns/1ps
// How it works
// - Every synchronous input sampled on rising clk
// - Burst counter supplies the two low bits
// - Low lane strobe writes, high means read
// - Lane strobes map one-to-one to lanes
// - Byte write gate high ignores lane strobes
// - Any gated lane strobe floats data pins
// - All-bytes write low writes all 36 bits
// - Primary select enables and qualifies processor strobe
// - Second select active high enables device
// - Optional third select, active low, must hold
// - Output enable gates drivers without the clock
// - Step input advances counter, high waits
// - Processor strobe with select starts a read
// - Controller strobe selects/deselects, read or write
// - Order input low linear, high interleaved
// - Sleep input high forces standby
module sbs_sram
  import sbs_pkg::*;
#(
  parameter int ADDR_W = SBS_ADDR_W,
  parameter bit HAS_THIRD_SELECT = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic chip_select_n,
  input wire logic second_select,
  input wire logic third_select_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic lane0_write_strobe_n,
  input wire logic lane1_write_strobe_n,
  input wire logic lane2_write_strobe_n,
  input wire logic lane3_write_strobe_n,
  input wire logic output_enable_n,
  input wire logic burst_order,
  input wire logic sleep_request,
  input wire logic [SBS_LANE_W-1:0] data_lane0_in,
  input wire logic [SBS_LANE_W-1:0] data_lane1_in,
  input wire logic [SBS_LANE_W-1:0] data_lane2_in,
  input wire logic [SBS_LANE_W-1:0] data_lane3_in,
  output logic [SBS_LANE_W-1:0] data_lane0_out,
  output logic [SBS_LANE_W-1:0] data_lane1_out,
  output logic [SBS_LANE_W-1:0] data_lane2_out,
  output logic [SBS_LANE_W-1:0] data_lane3_out,
  output logic [SBS_LANES-1:0] data_oe,
  output logic standby
);
  // ----------------------------------------
  // Decoded inputs
  // ----------------------------------------
  logic [SBS_LANES-1:0] lane_strobe_n;
  logic [SBS_DATA_W-1:0] din;
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic [SBS_LANES-1:0] lane_wr;
  logic any_wr;

  assign lane_strobe_n = {lane3_write_strobe_n, lane2_write_strobe_n,
    lane1_write_strobe_n, lane0_write_strobe_n};
  assign din = {data_lane3_in, data_lane2_in, data_lane1_in,
    data_lane0_in};
  assign selected = !chip_select_n && second_select &&
    (!HAS_THIRD_SELECT || !third_select_n);
  // Processor strobe starts a read only while the primary select is low
  assign proc_start = !proc_addr_strobe_n && !chip_select_n;
  assign ctrl_start = !ctrl_addr_strobe_n && proc_addr_strobe_n;

  always_comb begin
    if (!all_bytes_write_n) begin
      lane_wr = '1;
    end else if (!byte_write_gate_n) begin
      lane_wr = ~lane_strobe_n;
    end else begin
      lane_wr = '0;
    end
  end
  assign any_wr = |lane_wr;

  // ----------------------------------------
  // Access state and burst counter
  // ----------------------------------------
  sbs_state_t state_reg, state_next;
  logic [ADDR_W-1:0] base_reg, base_next;
  logic [SBS_OFS_W-1:0] start_reg, start_next;
  logic [SBS_OFS_W-1:0] count_reg, count_next;
  logic order_reg, order_next;
  logic [SBS_OFS_W-1:0] offset;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] start_addr;

  always_comb begin
    if (order_reg) begin
      offset = start_reg ^ count_reg;
    end else begin
      offset = start_reg + count_reg;
    end
  end
  // Low bits come from the counter, not from the pins
  assign cur_addr = {base_reg[ADDR_W-1:SBS_OFS_W], offset};
  assign start_addr = addr;

  always_comb begin
    state_next = state_reg;
    base_next = base_reg;
    start_next = start_reg;
    count_next = count_reg;
    order_next = order_reg;
    if (sleep_request) begin
      state_next = SBS_IDLE;
    end else if (proc_start) begin
      // Processor strobe always starts a read
      state_next = SBS_READ;
      base_next = start_addr;
      start_next = start_addr[SBS_OFS_W-1:0];
      count_next = SBS_OFS_ZERO;
      order_next = burst_order;
    end else if (ctrl_start) begin
      base_next = start_addr;
      start_next = start_addr[SBS_OFS_W-1:0];
      count_next = SBS_OFS_ZERO;
      order_next = burst_order;
      if (!selected) begin
        state_next = SBS_IDLE;
      end else if (any_wr) begin
        state_next = SBS_WRITE;
      end else begin
        state_next = SBS_READ;
      end
    end else if (state_reg != SBS_IDLE) begin
      if (!burst_step_n) begin
        count_next = count_reg + SBS_OFS_ONE;
      end
      // A write continuation follows the write controls of the cycle
      if (any_wr) begin
        state_next = SBS_WRITE;
      end else begin
        state_next = SBS_READ;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SBS_IDLE;
      base_reg <= '0;
      start_reg <= '0;
      count_reg <= '0;
      order_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      base_reg <= base_next;
      start_reg <= start_next;
      count_reg <= count_next;
      order_reg <= order_next;
    end
  end

  // ----------------------------------------
  // Write path and array
  // ----------------------------------------
  sbs_mem_if #(.AW(ADDR_W), .DW(SBS_DATA_W), .LN(SBS_LANES)) mbus ();
  logic [SBS_LANES-1:0] wlane_reg, wlane_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic [SBS_DATA_W-1:0] wdata_reg, wdata_next;
  logic rvalid_next;
  logic cont_wr;

  // Write data sampled in the same cycle as its address, on each burst beat
  assign cont_wr = (state_reg != SBS_IDLE) && !sleep_request &&
    !proc_start && !ctrl_start;

  always_comb begin
    wlane_next = '0;
    waddr_next = cur_addr;
    wdata_next = din;
    if (cont_wr && any_wr) begin
      wlane_next = lane_wr;
    end else if (ctrl_start && selected && any_wr && !sleep_request) begin
      wlane_next = lane_wr;
      waddr_next = start_addr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wlane_reg <= '0;
      waddr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      wlane_reg <= wlane_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  assign mbus.waddr = waddr_reg;
  assign mbus.wdata = wdata_reg;
  assign mbus.wlane = wlane_reg;
  assign mbus.raddr = cur_addr;

  sbs_mem #(.AW(ADDR_W), .LN(SBS_LANES), .LW(SBS_LANE_W)) u_mem (
    .clk(clk),
    .m(mbus.mem)
  );

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  logic drive_reg, drive_next;
  logic gated_wr;

  assign gated_wr = !byte_write_gate_n && (~lane_strobe_n != '0);
  assign rvalid_next = (state_reg == SBS_READ) && !sleep_request;
  // Read data valid one clock after the captured address
  assign drive_next = rvalid_next && !gated_wr;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign data_lane0_out = mbus.rdata[0*SBS_LANE_W +: SBS_LANE_W];
  assign data_lane1_out = mbus.rdata[1*SBS_LANE_W +: SBS_LANE_W];
  assign data_lane2_out = mbus.rdata[2*SBS_LANE_W +: SBS_LANE_W];
  assign data_lane3_out = mbus.rdata[3*SBS_LANE_W +: SBS_LANE_W];
  // Enable is combinational in output enable and sleep, no clock
  assign data_oe = {SBS_LANES{drive_reg && !output_enable_n &&
    !gated_wr && !sleep_request}};
  assign standby = sleep_request;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_proc_read;
    !proc_addr_strobe_n && !chip_select_n && !sleep_request;
  endsequence

  AST_PROC_READ: assert property (@(posedge clk) disable iff (sys_rst)
    s_proc_read |=> state_reg == SBS_READ)
    else $error("processor strobe did not start read");
  AST_PROC_GATED: assert property (@(posedge clk) disable iff (sys_rst)
    !proc_addr_strobe_n && chip_select_n && ctrl_addr_strobe_n &&
    state_reg == SBS_IDLE && !sleep_request |=> state_reg == SBS_IDLE)
    else $error("deselected processor strobe started access");
  AST_DESELECT: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_start && !second_select |=> state_reg == SBS_IDLE)
    else $error("controller strobe did not deselect");
  AST_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
    cont_wr && burst_step_n |=> $stable(count_reg))
    else $error("counter moved in wait cycle");
  AST_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    cont_wr && !burst_step_n |=> count_reg == $past(count_reg) + 2'h1)
    else $error("counter did not step");
  AST_LOW_BITS: assert property (@(posedge clk) disable iff (sys_rst)
    s_proc_read ##1 (!burst_step_n && cont_wr) |=>
    order_reg || cur_addr[1:0] == $past(start_reg) + 2'h1)
    else $error("linear burst offset wrong");
  AST_GLOBAL: assert property (@(posedge clk) disable iff (sys_rst)
    cont_wr && !all_bytes_write_n |=> wlane_reg == 4'hF)
    else $error("all-bytes write missed a lane");
  AST_GATE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    byte_write_gate_n && all_bytes_write_n |=> wlane_reg == 4'h0)
    else $error("lane strobe acted without gate");
  AST_FLOAT: assert property (@(posedge clk) disable iff (sys_rst)
    gated_wr |-> data_oe == 4'h0)
    else $error("drivers on during gated write");
  AST_OE: assert property (@(posedge clk) disable iff (sys_rst)
    output_enable_n |-> data_oe == 4'h0)
    else $error("drivers on with output enable high");
  AST_RD_LAT: assert property (@(posedge clk) disable iff (sys_rst)
    s_proc_read ##1 (!gated_wr && !sleep_request) |=> drive_reg)
    else $error("read data not one clock later");
  AST_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_request |=> state_reg == SBS_IDLE && !drive_reg)
    else $error("sleep did not force standby");

  // ----------------------------------------
  // Capture checks
  // ----------------------------------------
  sequence s_capture;
    (proc_start || ctrl_start) && !sleep_request;
  endsequence

  sequence s_ctrl_sel;
    ctrl_start && selected && !sleep_request;
  endsequence

  AST_STANDBY: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_request |-> standby && data_oe == 4'h0)
    else $error("standby or drivers wrong in sleep");
  AST_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
    s_capture |=> order_reg == $past(burst_order))
    else $error("burst order not taken at capture");
  AST_BASE: assert property (@(posedge clk) disable iff (sys_rst)
    proc_start && !sleep_request |=>
    base_reg == $past(addr) && count_reg == SBS_OFS_ZERO)
    else $error("processor strobe did not load address");
  AST_CTRL_WR: assert property (@(posedge clk) disable iff (sys_rst)
    s_ctrl_sel and any_wr |=>
    state_reg == SBS_WRITE && wlane_reg == $past(lane_wr))
    else $error("controller write not started");
  AST_CTRL_RD: assert property (@(posedge clk) disable iff (sys_rst)
    s_ctrl_sel and !any_wr |=> state_reg == SBS_READ)
    else $error("controller read not started");
  AST_WDATA: assert property (@(posedge clk) disable iff (sys_rst)
    s_ctrl_sel and any_wr |=>
    wdata_reg == $past(din) && waddr_reg == $past(addr))
    else $error("write data or address not captured");
  AST_THIRD: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_start && HAS_THIRD_SELECT && third_select_n |=>
    state_reg == SBS_IDLE)
    else $error("third select high did not deselect");
  AST_LANE_MAP: assert property (@(posedge clk) disable iff (sys_rst)
    cont_wr && !byte_write_gate_n && all_bytes_write_n |=>
    wlane_reg == ~$past(lane_strobe_n))
    else $error("lane strobe drove wrong lane");
  AST_NO_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg != SBS_READ |=> !drive_reg)
    else $error("drivers armed outside a read");
endmodule

// file: tb/sbs_master.sv
`timescale 1ns/1ps
module sbs_master
  import sbs_pkg::*;
(
  input wire logic clk,
  output logic [SBS_ADDR_W-1:0] addr,
  output logic chip_select_n,
  output logic second_select,
  output logic third_select_n,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_step_n,
  output logic all_bytes_write_n,
  output logic byte_write_gate_n,
  output logic [SBS_LANES-1:0] lane_strobe_n,
  output logic [SBS_DATA_W-1:0] dq
);
  initial begin
    {chip_select_n, second_select, third_select_n} = 3'h2;
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
    {all_bytes_write_n, byte_write_gate_n, lane_strobe_n} = 6'h3F;
    addr = '0;
    dq = '0;
  end
  // Selects change at once; callers are already past a falling edge
  task sel(input logic [2:0] s);
    {chip_select_n, second_select, third_select_n} = s;
  endtask
  task beat(input logic [2:0] stb, input logic [5:0] wr,
    input logic [SBS_ADDR_W-1:0] a, input logic [SBS_DATA_W-1:0] d);
    @(negedge clk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = stb;
    {all_bytes_write_n, byte_write_gate_n, lane_strobe_n} = wr;
    addr = a;
    // Released bus flips each beat so a stale value never passes
    dq = (!wr[5] || (!wr[4] && wr[3:0] != 4'hF)) ? d : ~dq;
  endtask
endmodule

// file: tb/sync_burst_sram_pin_interface_test.sv
`timescale 1ns/1ps
module sync_burst_sram_pin_interface_test;
  import sbs_pkg::*;
  localparam logic [17:0] A = 18'h00104;
  localparam logic [35:0] D = 36'h912345678;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic oe_n = 1'b0;
  logic order = 1'b0;
  logic sleep = 1'b0;
  logic [SBS_ADDR_W-1:0] addr;
  logic chip_select_n, second_select, third_select_n, proc_addr_strobe_n;
  logic ctrl_addr_strobe_n, burst_step_n, all_bytes_write_n;
  logic byte_write_gate_n, standby;
  logic [SBS_LANES-1:0] lane_strobe_n, oe;
  logic [SBS_DATA_W-1:0] mdq, dout, bus;
  int bad_count = 0;
  int num_checks = 0;
  initial forever #10 clk = ~clk;
  always_comb begin
    for (int i = 0; i < SBS_LANES; i++) begin
      bus[i*9 +: 9] = oe[i] ? dout[i*9 +: 9] : mdq[i*9 +: 9];
    end
  end
  sbs_master m (.clk, .addr, .chip_select_n, .second_select,
    .third_select_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_step_n, .all_bytes_write_n, .byte_write_gate_n,
    .lane_strobe_n, .dq(mdq));
  sbs_sram dut (.clk, .sys_rst, .addr, .chip_select_n, .second_select,
    .third_select_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_step_n, .all_bytes_write_n, .byte_write_gate_n,
    .lane0_write_strobe_n(lane_strobe_n[0]),
    .lane1_write_strobe_n(lane_strobe_n[1]),
    .lane2_write_strobe_n(lane_strobe_n[2]),
    .lane3_write_strobe_n(lane_strobe_n[3]),
    .output_enable_n(oe_n), .burst_order(order), .sleep_request(sleep),
    .data_lane0_in(bus[8:0]), .data_lane1_in(bus[17:9]),
    .data_lane2_in(bus[26:18]), .data_lane3_in(bus[35:27]),
    .data_lane0_out(dout[8:0]), .data_lane1_out(dout[17:9]),
    .data_lane2_out(dout[26:18]), .data_lane3_out(dout[35:27]),
    .data_oe(oe), .standby);
  task chk(input string what, input logic [35:0] seen, input logic [35:0] e);
    num_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function logic [35:0] word(input logic [1:0] o);
    return 36'hA5A5A5A50 + 36'(o);
  endfunction
  task nop;
    m.beat(3'h7, 6'h3F, '0, '0);
  endtask
  task wr(input logic [17:0] a, input logic [35:0] d, input logic [5:0] w);
    m.beat(3'h5, w, a, d);
    nop;
    nop;
  endtask
  task rd_chk(input logic [17:0] a, input logic [35:0] e);
    m.beat(3'h3, 6'h3F, a, '0);
    nop;
    nop;
    chk("rdata", bus, e);
    chk("rdrive", oe, 4'hF);
  endtask
  task t_full;
    m.beat(3'h5, 6'h1F, A, D);
    nop;
    chk("oe_gw", oe, 4'h0);
    nop;
    rd_chk(A, D);
    oe_n = 1'b1;
    #1 chk("oe_off", oe, 4'h0);
    oe_n = 1'b0;
  endtask
  task t_lanes;
    logic [35:0] e;
    e = D;
    for (int i = 0; i < 4; i++) begin
      m.beat(3'h5, {2'h2, ~(4'h1 << i)}, A, ~D);
      #1 chk("oe_lane", oe, 4'h0);
      nop;
      nop;
      e[i*9 +: 9] = ~D[i*9 +: 9];
      rd_chk(A, e);
    end
    // Strobes low but gate high: must act as a read
    wr(A, '0, 6'h30);
    rd_chk(A, e);
  endtask
  task t_burst(input logic ord);
    logic [1:0] n;
    for (int j = 0; j < 4; j++) wr(18'h00200 + 18'(j), word(2'(j)), 6'h20);
    order = ord;
    m.beat(3'h3, 6'h3F, 18'h00201, '0);
    for (int k = 0; k < 6; k++) begin
      // Address pins carry junk; wait cycle at k == 1
      m.beat({2'h3, k == 1}, 6'h3F, 18'h3FFFF, '0);
      if (k > 0) begin
        n = 2'(k - 1 - (k > 2));
        chk("burst", bus, word(ord ? 2'h1 ^ n : 2'h1 + n));
      end
    end
  endtask
  task t_select;
    logic [2:0] s;
    for (int i = 0; i < 3; i++) begin
      s = (i == 0) ? 3'h0 : (i == 1) ? 3'h3 : 3'h6;
      m.beat(3'h3, 6'h3F, A, '0);
      nop;
      nop;
      chk("sel_on", oe, 4'hF);
      m.sel(s);
      m.beat(3'h5, 6'h3F, A, '0);
      nop;
      m.sel(3'h2);
      nop;
      chk("sel_off", oe, 4'h0);
    end
    m.sel(3'h6);
    m.beat(3'h3, 6'h3F, A, '0);
    nop;
    m.sel(3'h2);
    nop;
    chk("proc_cs", oe, 4'h0);
  endtask
  task t_sleep;
    rd_chk(A, 36'h6EDCBA987);
    sleep = 1'b1;
    #1 chk("stby", standby, 1'b1);
    nop;
    nop;
    chk("sleep_oe", oe, 4'h0);
    sleep = 1'b0;
    #1 chk("wake", standby, 1'b0);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    chk("rst_oe", oe, 4'h0);
    chk("rst_stby", standby, 1'b0);
    sys_rst = 1'b0;
    t_full;
    t_lanes;
    t_burst(1'b0);
    t_burst(1'b1);
    t_select;
    t_sleep;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    conclude;
  end
endmodule
